// *** bench/scb_assertions.sv ***
// Port checks for the serial clock and buffer select block
`timescale 1ns/10ps
`default_nettype none
module scb_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Clock results
  input wire logic bit_tick,
  input wire logic sclk_out,
  input wire logic sclk_out_en,
  input wire logic tx_double,
  input wire logic rx_double
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------
  // Bus phases
  // ----------------
  sequence rd_far_s;
    hsel && hready && htrans == scb_pkg::HTRANS_NONSEQ && !hwrite && haddr[11:0] >= 12'h01C;
  endsequence
  sequence data_s;
    ##1 hreadyout;
  endsequence
  // ----------------
  // Checks
  // ----------------
  unmapped_read_a: assert property (rd_far_s ##0 data_s |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  okay_ready_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  tx_rx_double_a: assert property (tx_double |-> rx_double)
    else $error("rx single while tx double");
  ext_rx_double_a: assert property (!sclk_out_en |-> rx_double)
    else $error("rx single without clock output");
  out_single_a: assert property (sclk_out_en && !tx_double |-> !rx_double)
    else $error("rx double in clock output single mode");
  shift_rise_a: assert property (sclk_out_en && bit_tick |-> sclk_out)
    else $error("shift tick not on rising clock output");
  bit_pulse_a: assert property (bit_tick |=> !bit_tick)
    else $error("bit tick longer than one cycle");
  reset_single_a: assert property ($rose(hresetn) |-> sclk_out_en && !tx_double && !rx_double)
    else $error("buffers not single after reset");
  frozen_state_a: assert property (!clk_en |=> $stable(sclk_out) && $stable(tx_double))
    else $error("state moved while frozen");
endmodule
bind scb_top scb_assertions i_scb_assertions (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .bit_tick(bit_tick), .sclk_out(sclk_out), .sclk_out_en(sclk_out_en), .tx_double(tx_double),
  .rx_double(rx_double));
`default_nettype wire

// *** bench/scb_peer_model.sv ***
// External serial clock source and prescaler tick source
`timescale 1ns/10ps
`default_nettype none
module scb_peer_model (
  // Clock
  input wire logic hclk,
  // Control from the bench
  input wire logic run,
  input wire logic [7:0] high_cyc,
  input wire logic [7:0] low_cyc,
  // Clock outputs
  output logic prescale_tick,
  output logic ext_sclk
);
  logic [7:0] cnt = 8'h00;
  // Prescaler pulse every second cycle, no faster than fsys/2
  initial prescale_tick = 1'b0;
  always @(posedge hclk) prescale_tick <= !prescale_tick;
  initial ext_sclk = 1'b0;
  always @(posedge hclk) begin
    if (!run) begin
      ext_sclk <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt >= (ext_sclk ? high_cyc : low_cyc) - 8'h01) begin
      ext_sclk <= !ext_sclk;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** bench/test_scb_top.sv ***
// Self-checking bench for the serial clock and buffer select block
`timescale 1ns/10ps
`default_nettype none
module test_scb_top;
  logic hclk, hresetn, clk_en, hsel, hwrite, run;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] hi_cyc, lo_cyc;
  logic hreadyout, hresp, prescale_tick, ext_sclk, sio_tick, bit_tick, sclk_out, sclk_out_en, tx_double, rx_double;
  int num_errors = 0;
  int num_checks = 0;
  int n, m;
  // ----------------
  // Design and peer
  // ----------------
  scb_top i_scb_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .prescale_tick(prescale_tick), .ext_sclk(ext_sclk),
    .sio_tick(sio_tick), .bit_tick(bit_tick), .sclk_out(sclk_out), .sclk_out_en(sclk_out_en),
    .tx_double(tx_double), .rx_double(rx_double));
  scb_peer_model i_scb_peer_model (.hclk(hclk), .run(run), .high_cyc(hi_cyc), .low_cyc(lo_cyc),
    .prescale_tick(prescale_tick), .ext_sclk(ext_sclk));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = !hclk;
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  // One single transfer of size z, address phase then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] z,
    output logic [31:0] r);
    haddr <= {20'h00000, a};
    hwrite <= w;
    hsize <= z;
    htrans <= scb_pkg::HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, scb_pkg::HSIZE_WORD, rd);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h00000000, scb_pkg::HSIZE_WORD, rd);
    chk(rd, e, s);
  endtask
  // Cycles between two events: 0 is a rise of sclk_out, 1 is bit_tick
  task automatic gap(input int w, output int c);
    int k;
    int seen;
    logic p;
    seen = 0;
    c = 0;
    p = 1'b1;
    for (k = 0; k < 6000 && seen < 2; k++) begin
      @(posedge hclk);
      if (seen == 1) c++;
      if ((w == 0) ? (sclk_out === 1'b1 && !p) : (bit_tick === 1'b1)) seen++;
      p = sclk_out;
    end
  endtask
  // Cycles from a rise of the external clock to the next bit_tick
  task automatic lat(output int c);
    logic p;
    p = 1'b1;
    c = 0;
    for (int k = 0; k < 100; k++) begin
      @(posedge hclk);
      if (c > 0 || (ext_sclk && !p)) c++;
      p = ext_sclk;
      if (c > 0 && bit_tick === 1'b1) k = 100;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset_regs();
    chk(tx_double, 1'b0, "tx reset");
    chk(rx_double, 1'b0, "rx reset");
    rdc(scb_pkg::BAUD_CONTROL_OFS, 32'h00000002, "baud reset");
    rdc(scb_pkg::TIMER_COMPARE_OFS, 32'h00000001, "compare reset");
    wr(scb_pkg::BAUD_CONTROL_OFS, 32'hFFFFFFFF);
    rdc(scb_pkg::BAUD_CONTROL_OFS, 32'h0000007F, "baud control");
    wr(12'h01C, 32'hFFFFFFFF);
    rdc(12'h01C, 32'h00000000, "unmapped");
    bus(1'b1, scb_pkg::BAUD_FRACTION_OFS, 32'h00000005, 3'h0, rd);
    rdc(scb_pkg::BAUD_FRACTION_OFS, 32'h00000000, "byte write");
  endtask
  task automatic t_buffers();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(scb_pkg::MODE0_OFS, {28'h0000000, 1'b0, c[2], scb_pkg::CLK_SYS});
      wr(scb_pkg::SERIAL_CONTROL_OFS, {30'h0, c[1], 1'b0});
      wr(scb_pkg::MODE2_OFS, {31'h0, c[0]});
      repeat (2) @(posedge hclk);
      chk(tx_double, c[0], "tx buffer");
      chk(rx_double, c[0] | c[1] | c[2], "rx buffer");
      chk(sclk_out_en, !(c[1] | c[2]), "clock out enable");
    end
  endtask
  task automatic t_io_div();
    logic [6:0] v [6] = '{7'h01, 7'h02, 7'h12, 7'h22, 7'h32, 7'h00};
    int e [6] = '{8, 16, 64, 256, 1024, 128};
    wr(scb_pkg::MODE0_OFS, 32'h00000000);
    wr(scb_pkg::SERIAL_CONTROL_OFS, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      // Ratio one only with double buffer
      wr(scb_pkg::MODE2_OFS, (i == 0) ? 32'h00000001 : 32'h00000000);
      wr(scb_pkg::BAUD_CONTROL_OFS, {25'h0, v[i]});
      gap(0, n);
      gap(0, n);
      chk(n, e[i], "io clock period");
    end
  endtask
  task automatic t_uart();
    wr(scb_pkg::MODE0_OFS, {28'h0000000, 2'h1, scb_pkg::CLK_SYS});
    gap(1, n);
    gap(1, n);
    chk(n, 16, "fsys bit period");
    chk(sio_tick, 1'b1, "fsys tick");
    clk_en <= 1'b0;
    m = 0;
    repeat (40) begin
      @(posedge hclk);
      if (bit_tick !== 1'b0) m++;
    end
    clk_en <= 1'b1;
    chk(m, 0, "frozen bit tick");
    wr(scb_pkg::MODE0_OFS, {28'h0000000, 2'h1, scb_pkg::CLK_BAUD});
    wr(scb_pkg::BAUD_FRACTION_OFS, 32'h0000000C);
    wr(scb_pkg::BAUD_CONTROL_OFS, 32'h00000003);
    gap(1, n);
    gap(1, n);
    chk(n, 192, "divide by n");
    wr(scb_pkg::BAUD_CONTROL_OFS, 32'h00000043);
    gap(1, n);
    gap(1, n);
    chk(n, 208, "fractional divide");
    // Compare of three: toggle every 6 cycles, rise every 12, bit every 192
    wr(scb_pkg::TIMER_COMPARE_OFS, 32'h00000003);
    wr(scb_pkg::MODE0_OFS, {28'h0000000, 2'h1, scb_pkg::CLK_TIMER});
    gap(1, n);
    gap(1, n);
    chk(n, 192, "timer source bit period");
  endtask
  task automatic t_ext();
    run <= 1'b1;
    wr(scb_pkg::MODE0_OFS, {28'h0000000, 2'h1, scb_pkg::CLK_EXT});
    gap(1, n);
    gap(1, n);
    chk(n, 96, "ext uart bit period");
    // Period ten, above single buffer limit
    hi_cyc <= 8'h04;
    lo_cyc <= 8'h06;
    wr(scb_pkg::MODE0_OFS, 32'h00000000);
    wr(scb_pkg::SERIAL_CONTROL_OFS, 32'h00000002);
    gap(1, n);
    gap(1, n);
    chk(n, 10, "ext io shift period");
    lat(n);
    lat(n);
    wr(scb_pkg::SERIAL_CONTROL_OFS, 32'h00000003);
    lat(m);
    lat(m);
    chk(m - n, 4, "falling edge shift");
    run <= 1'b0;
  endtask
  // Watchdog
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, run, haddr, hwdata, htrans} = '0;
    clk_en = 1'b1;
    hsize = scb_pkg::HSIZE_WORD;
    hi_cyc = 8'h03;
    lo_cyc = 8'h03;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_regs();
    t_buffers();
    t_io_div();
    t_uart();
    t_ext();
    give_verdict();
  end
endmodule
`default_nettype wire

// *** logic/scb_pkg.sv ***
// Constants, register map and field layouts for the serial clock and buffer select block
package scb_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] BAUD_CONTROL_OFS = 12'h000;
  localparam logic [11:0] BAUD_FRACTION_OFS = 12'h004;
  localparam logic [11:0] MODE0_OFS = 12'h008;
  localparam logic [11:0] SERIAL_CONTROL_OFS = 12'h00C;
  localparam logic [11:0] MODE2_OFS = 12'h010;
  localparam logic [11:0] TIMER_COMPARE_OFS = 12'h014;
  localparam logic [11:0] STATUS_OFS = 12'h018;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Baud control: divisor [3:0], prescale select [5:4], fraction enable [6]
  localparam int BC_DIV_LSB = 0;
  localparam int BC_PRE_LSB = 4;
  localparam int BC_FRAC_BIT = 6;
  localparam int BC_WIDTH = 7;
  // Mode 0: clock select [1:0], mode [3:2]
  localparam int M0_CLK_LSB = 0;
  localparam int M0_MODE_LSB = 2;
  localparam int M0_WIDTH = 4;
  // Serial control: edge select [0], clock direction (1 = input) [1]
  localparam int SC_EDGE_BIT = 0;
  localparam int SC_DIR_BIT = 1;
  localparam int SC_WIDTH = 2;
  // Mode 2: buffer select [0]
  localparam int M2_BUF_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_IO = 2'h0;
  localparam logic [1:0] CLK_TIMER = 2'h0;
  localparam logic [1:0] CLK_BAUD = 2'h1;
  localparam logic [1:0] CLK_SYS = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [3:0] DIV_RESET = 4'h2;
  localparam logic [3:0] FRAC_FULL = 4'hF;
  localparam logic [3:0] PHASE_TOP = 4'hF;
  localparam logic [6:0] PRE_DIV8 = 7'h07;
  localparam logic [6:0] PRE_DIV32 = 7'h1F;
  localparam logic [6:0] PRE_DIV128 = 7'h7F;
  localparam logic [15:0] CMP_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// *** logic/scb_top.sv ***
// Serial transfer clock generator with buffer depth selection and AHB-Lite registers
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Baud input picks prescaler output divided by 2, 8, 32 or 128.
// - I/O mode divides baud input by N from 1 to 16.
// - UART mode divides by N, or by N + (16-K)/16 when enabled and K is nonzero.
// - Mode field sets mode; control register or clock select picks clock.
// - I/O clock output is baud output halved, rising edge only.
// - I/O external clock shifts on rising or falling edge by edge select.
// - UART clock divided by 16 in bit counter forms bit period.
// - UART clock select: timer, baud generator, fsys or external clock.
// - Timer source toggles a flip-flop on each compare match.
// - Transmit buffer single when buffer select is 0, double when 1.
// - Receive buffer double in UART and external I/O, else follows select.
module scb_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock sources
  input wire logic prescale_tick,
  input wire logic ext_sclk,
  // Serial clock results
  output logic sio_tick,
  output logic bit_tick,
  output logic sclk_out,
  output logic sclk_out_en,
  output logic tx_double,
  output logic rx_double
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [6:0] baud_control_reg;
  logic [3:0] baud_fraction_reg;
  logic [3:0] mode_reg0;
  logic [1:0] serial_control_reg;
  logic mode_reg2;
  logic [15:0] timer_compare_reg;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;

  // Divider state
  logic [6:0] pre_cnt_reg;
  logic [3:0] baud_cnt_reg;
  logic [3:0] frac_phase_reg;
  logic baud_tick_reg;
  logic half_reg;
  logic [15:0] tmr_cnt_reg;
  logic tmr_ff_reg;
  logic tmr_ff_d_reg;
  logic ext_d_reg;
  logic [3:0] bit_cnt_reg;
  logic sio_tick_reg;
  logic bit_tick_reg;

  // Decoded fields
  logic [3:0] divisor;
  logic [1:0] prescale_select;
  logic frac_en;
  logic [1:0] uart_clock_select;
  logic [1:0] serial_mode_field;
  logic edge_sel;
  logic clk_is_input;
  logic io_mode;
  logic pre_hit;
  logic baud_in;
  logic stretch;
  logic [4:0] target;
  logic ext_rise;
  logic ext_fall;
  logic src_tick;

  // Local aliases for package names
  localparam int BC_DIV_LSB = scb_pkg::BC_DIV_LSB;
  localparam int BC_PRE_LSB = scb_pkg::BC_PRE_LSB;
  localparam int BC_FRAC_BIT = scb_pkg::BC_FRAC_BIT;
  localparam int M0_CLK_LSB = scb_pkg::M0_CLK_LSB;
  localparam int M0_MODE_LSB = scb_pkg::M0_MODE_LSB;
  localparam int SC_EDGE_BIT = scb_pkg::SC_EDGE_BIT;
  localparam int SC_DIR_BIT = scb_pkg::SC_DIR_BIT;

  assign divisor = baud_control_reg[BC_DIV_LSB +: 4];
  assign prescale_select = baud_control_reg[BC_PRE_LSB +: 2];
  assign frac_en = baud_control_reg[BC_FRAC_BIT];
  assign uart_clock_select = mode_reg0[M0_CLK_LSB +: 2];
  assign serial_mode_field = mode_reg0[M0_MODE_LSB +: 2];
  assign edge_sel = serial_control_reg[SC_EDGE_BIT];
  assign clk_is_input = serial_control_reg[SC_DIR_BIT];

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divisor field of zero stands for sixteen
  function automatic logic [4:0] div_value(input logic [3:0] f);
    div_value = (f == 4'h0) ? 5'h10 : {1'b0, f};
  endfunction

  // Word-aligned offset match within the block
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic addr_valid;
  assign addr_valid = hsel && hready && (htrans == scb_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (clk_en) begin
      wr_pend_reg <= addr_valid && hwrite && (hsize == scb_pkg::HSIZE_WORD);
      wr_addr_reg <= haddr[11:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_control_reg <= {3'h0, scb_pkg::DIV_RESET};
      baud_fraction_reg <= 4'h0;
      mode_reg0 <= 4'h0;
      serial_control_reg <= 2'h0;
      mode_reg2 <= 1'b0;
      timer_compare_reg <= scb_pkg::CMP_RESET;
    end else if (clk_en && wr_pend_reg) begin
      if (hit(wr_addr_reg, scb_pkg::BAUD_CONTROL_OFS)) begin
        baud_control_reg <= hwdata[scb_pkg::BC_WIDTH-1:0];
      end
      if (hit(wr_addr_reg, scb_pkg::BAUD_FRACTION_OFS)) begin
        baud_fraction_reg <= hwdata[3:0];
      end
      if (hit(wr_addr_reg, scb_pkg::MODE0_OFS)) begin
        mode_reg0 <= hwdata[scb_pkg::M0_WIDTH-1:0];
      end
      if (hit(wr_addr_reg, scb_pkg::SERIAL_CONTROL_OFS)) begin
        serial_control_reg <= hwdata[scb_pkg::SC_WIDTH-1:0];
      end
      if (hit(wr_addr_reg, scb_pkg::MODE2_OFS)) begin
        mode_reg2 <= hwdata[scb_pkg::M2_BUF_BIT];
      end
      if (hit(wr_addr_reg, scb_pkg::TIMER_COMPARE_OFS)) begin
        timer_compare_reg <= hwdata[15:0];
      end
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && addr_valid && !hwrite) begin
      case (haddr[11:0])
        scb_pkg::BAUD_CONTROL_OFS: hrdata <= {25'h0, baud_control_reg};
        scb_pkg::BAUD_FRACTION_OFS: hrdata <= {28'h0, baud_fraction_reg};
        scb_pkg::MODE0_OFS: hrdata <= {28'h0, mode_reg0};
        scb_pkg::SERIAL_CONTROL_OFS: hrdata <= {30'h0, serial_control_reg};
        scb_pkg::MODE2_OFS: hrdata <= {31'h0, mode_reg2};
        scb_pkg::TIMER_COMPARE_OFS: hrdata <= {16'h0, timer_compare_reg};
        scb_pkg::STATUS_OFS: hrdata <= {24'h0, bit_cnt_reg, rx_double, tx_double, tmr_ff_reg, half_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  // mode decode
  assign io_mode = (serial_mode_field == scb_pkg::MODE_IO);

  always_comb begin
    case (prescale_select)
      2'h0: pre_hit = 1'b1;
      2'h1: pre_hit = (pre_cnt_reg[2:0] == scb_pkg::PRE_DIV8[2:0]);
      2'h2: pre_hit = (pre_cnt_reg[4:0] == scb_pkg::PRE_DIV32[4:0]);
      default: pre_hit = (pre_cnt_reg == scb_pkg::PRE_DIV128);
    endcase
  end

  // Prescaler tick divided by the tap: 2, 8, 32 or 128
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_reg <= 7'h00;
    end else if (clk_en && prescale_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end
  assign baud_in = clk_en && prescale_tick && pre_cnt_reg[0] && pre_hit;

  assign stretch = !io_mode && frac_en && (frac_phase_reg < (scb_pkg::FRAC_FULL - baud_fraction_reg + 4'h1))
                   && (baud_fraction_reg != 4'h0);
  assign target = div_value(divisor) + {4'h0, stretch};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_reg <= 4'h0;
      frac_phase_reg <= 4'h0;
      baud_tick_reg <= 1'b0;
    end else if (clk_en) begin
      baud_tick_reg <= 1'b0;
      if (baud_in) begin
        if ({1'b0, baud_cnt_reg} + 5'h01 >= target) begin
          baud_cnt_reg <= 4'h0;
          baud_tick_reg <= 1'b1;
          frac_phase_reg <= frac_phase_reg + 4'h1;
        end else begin
          baud_cnt_reg <= baud_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer source and external clock edges
  // ----------------------------------------------------------------
  // toggle on compare match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_cnt_reg <= 16'h0000;
      tmr_ff_reg <= 1'b0;
      tmr_ff_d_reg <= 1'b0;
    end else if (clk_en) begin
      tmr_ff_d_reg <= tmr_ff_reg;
      if (prescale_tick) begin
        if (tmr_cnt_reg + 16'h0001 >= timer_compare_reg) begin
          tmr_cnt_reg <= 16'h0000;
          tmr_ff_reg <= !tmr_ff_reg;
        end else begin
          tmr_cnt_reg <= tmr_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // External clock sampled as a synchronous input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_d_reg <= 1'b0;
    end else if (clk_en) begin
      ext_d_reg <= ext_sclk;
    end
  end
  assign ext_rise = ext_sclk && !ext_d_reg;
  assign ext_fall = !ext_sclk && ext_d_reg;

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  // UART source, I/O edge select
  always_comb begin
    if (io_mode) begin
      if (clk_is_input) begin
        src_tick = edge_sel ? ext_fall : ext_rise;
      end else begin
        src_tick = baud_tick_reg && !half_reg; // Shift as the clock output rises
      end
    end else begin
      case (uart_clock_select)
        scb_pkg::CLK_TIMER: src_tick = tmr_ff_reg && !tmr_ff_d_reg;
        scb_pkg::CLK_BAUD: src_tick = baud_tick_reg;
        scb_pkg::CLK_SYS: src_tick = 1'b1;
        scb_pkg::CLK_EXT: src_tick = ext_rise;
        default: src_tick = 1'b0;
      endcase
    end
  end

  // clock output is baud output halved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_reg <= 1'b0;
    end else if (clk_en && baud_tick_reg) begin
      half_reg <= !half_reg;
    end
  end

  // divide by 16 for the UART bit period, every source tick in I/O mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_reg <= 4'h0;
      sio_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else if (clk_en) begin
      sio_tick_reg <= src_tick;
      bit_tick_reg <= 1'b0;
      if (src_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        bit_tick_reg <= io_mode || (bit_cnt_reg == scb_pkg::PHASE_TOP);
      end
    end
  end

  assign sio_tick = sio_tick_reg;
  assign bit_tick = bit_tick_reg;
  assign sclk_out = half_reg;
  assign sclk_out_en = io_mode && !clk_is_input;

  // ----------------------------------------------------------------
  // Buffer depth
  // ----------------------------------------------------------------
  // transmit follows buffer select
  assign tx_double = mode_reg2;
  // receive forced double except I/O clock output
  assign rx_double = mode_reg2 || !io_mode || clk_is_input;

endmodule
`default_nettype wire
